// ---- hdl/lmi_pkg.sv ----
// Purpose: Shared constants and types of the LED matrix scan controller
// Assumes: 10 MHz core clock, registers reached only over the two-wire port
// Notes:   Timing counts are derived from the core clock rate
// Function
// - Answer only bus address 1011010, carried in the first byte's top bits.
// - Lowest address bit zero means write, one means read.
// - Data line is sampled while the clock is steadily high.
// - Data falling with clock high is a start; address compare follows.
// - Matching address is acknowledged by pulling data low on ninth pulse.
// - Register-address byte follows, msb first, and is acknowledged.
// - Every received data byte, msb first, is acknowledged.
// - Data rising with clock high is a stop and ends the transaction.
// - Pointer advances by one during each data byte acknowledge.
// - Pointer keeps advancing for every further byte in a transaction.
// - Read: write address and pointer, repeated start, read address, data.
// - Serial port works at clock rates up to 1 MHz.
// - Shutdown pin low stops all operation.
// - Shutdown pin rising edge resets the serial logic.
// - All rows and columns off for a blanking gap between rows.
// - Lower half of the columns switches on with the row source, upper half shortly after.
// - Each row stays on for a nominal 5 us at the default rate.
// - Support 8x7, 9x6 and 10xn matrices, scanning without host traffic.
// - One global 7-bit current code drives all LEDs.

package lmi_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam logic [6:0] BUS_ADDR      = 7'h5a;
    localparam int         REG_COUNT     = 16;
    localparam logic [7:0] REG_CFG       = 8'h00;
    localparam logic [7:0] REG_ONOFF_0   = 8'h01;
    localparam logic [7:0] REG_GCC       = 8'h0b;
    localparam logic [7:0] REG_SCAN      = 8'h0c;
    localparam logic [7:0] REG_OS_EN     = 8'h0d;
    localparam logic [7:0] REG_OS_STAT   = 8'h0e;
    localparam logic [7:0] CFG_RESET     = 8'h01;
    localparam logic [7:0] GCC_RESET     = 8'h7f;
    localparam logic [7:0] SCAN_RESET    = 8'h01;
    localparam int         CFG_RUN_BIT   = 0;
    localparam int         CFG_MODE_LSB  = 4;
    localparam int         SCAN_RATE_LSB = 0;

    // ------------------------------------------------------------------
    // Matrix geometry and timing
    // ------------------------------------------------------------------
    localparam int  ROWS_MAX     = 7;
    localparam int  COLS_MAX     = 10;
    localparam real CLK_MHZ      = 10.0;
    localparam real BLANK_US     = 0.18;
    localparam real STAGGER_US   = 0.01;
    localparam real SCAN_US      = 5.0;
    localparam int  BLANK_RAW    = int'($ceil(BLANK_US * CLK_MHZ));
    localparam int  STAGGER_RAW  = int'($ceil(STAGGER_US * CLK_MHZ));
    localparam int  BLANK_CYC    = (BLANK_RAW < 1) ? 1 : BLANK_RAW;
    localparam int  STAGGER_CYC  = (STAGGER_RAW < 1) ? 1 : STAGGER_RAW;
    localparam int  SCAN_CYC     = int'($floor(SCAN_US * CLK_MHZ));
    localparam int  CNT_W        = 16;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_ACK, ST_RDATA, ST_MACK
    } lmi_i2c_e;

    typedef enum logic {PH_BLANK, PH_ON} lmi_phase_e;

    typedef struct packed {
        logic [ROWS_MAX-1:0] row;
        logic [COLS_MAX-1:0] col;
    } lmi_drive_s;

    typedef struct packed {
        logic [2:0]                 scl_sync;
        logic [2:0]                 sda_sync;
        logic [2:0]                 sdn_sync;
        logic                       scl_s;
        logic                       sda_s;
        logic                       sdn_s;
        lmi_i2c_e                   st;
        lmi_i2c_e                   ack_next;
        logic [2:0]                 bit_cnt;
        logic                       full;
        logic [7:0]                 shift;
        logic [7:0]                 ptr;
        logic                       sda_oe_n;
        logic [6:0]                 level;
        logic [REG_COUNT-1:0][7:0]  regs;
    } lmi_top_s;

    typedef struct packed {
        lmi_phase_e       phase;
        logic [CNT_W-1:0] cnt;
        logic [2:0]       row;
        lmi_drive_s       drive;
    } lmi_scan_s;

endpackage : lmi_pkg

// ---- hdl/lmi_scan_seq.sv ----
// Purpose: Row/column scan sequencer of the LED matrix
// Assumes: Enable and geometry come from the register logic on the same clock
// Notes:   Outputs are registered inside the drive struct

`timescale 1ns/100ps

module lmi_scan_seq #(
    parameter int BLANK_CYC   = lmi_pkg::BLANK_CYC,
    parameter int STAGGER_CYC = lmi_pkg::STAGGER_CYC,
    parameter int SCAN_CYC    = lmi_pkg::SCAN_CYC
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Control
    input  wire logic                         en_i,
    input  wire logic [2:0]                   row_count_i,
    input  wire logic [3:0]                   col_count_i,
    input  wire logic [6:0]                   rate_mult_i,
    input  wire logic [lmi_pkg::COLS_MAX-1:0]
                      [lmi_pkg::ROWS_MAX-1:0] onoff_i,
    // Drive
    output lmi_pkg::lmi_drive_s               drive_o
);

    lmi_pkg::lmi_scan_s q;
    lmi_pkg::lmi_scan_s d;
    logic [lmi_pkg::CNT_W-1:0] on_len;

    // Slower scan settings stretch the on time of each row
    assign on_len = lmi_pkg::CNT_W'(SCAN_CYC) *
                    lmi_pkg::CNT_W'(rate_mult_i);

    always_comb begin
        d       = q;
        d.drive = '0;
        if (!en_i) begin
            d.phase = lmi_pkg::PH_BLANK;
            d.cnt   = '0;
            d.row   = '0;
        end else begin
            unique case (q.phase)
                lmi_pkg::PH_BLANK: begin
                    d.cnt = q.cnt + lmi_pkg::CNT_W'(1);
                    if (q.cnt == lmi_pkg::CNT_W'(BLANK_CYC - 1)) begin
                        d.phase = lmi_pkg::PH_ON;
                        d.cnt   = '0;
                    end
                end
                lmi_pkg::PH_ON: begin
                    d.cnt = q.cnt + lmi_pkg::CNT_W'(1);
                    if (q.cnt == on_len - lmi_pkg::CNT_W'(1)) begin
                        d.phase = lmi_pkg::PH_BLANK;
                        d.cnt   = '0;
                        if (q.row >= row_count_i - 3'h1) begin
                            d.row = '0;
                        end else begin
                            d.row = q.row + 3'h1;
                        end
                    end
                end
            endcase
            if (d.phase == lmi_pkg::PH_ON) begin
                d.drive.row[d.row] = 1'b1;
                for (int c = 0; c < lmi_pkg::COLS_MAX; c++) begin
                    // Upper half of the sinks lags the lower half
                    d.drive.col[c] = onoff_i[c][d.row] &&
                        (4'(c) < col_count_i) &&
                        ((c < lmi_pkg::COLS_MAX / 2) ||
                         (d.cnt >= lmi_pkg::CNT_W'(STAGGER_CYC)));
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign drive_o = q.drive;

endmodule // lmi_scan_seq

// ---- hdl/lmi_ctrl.sv ----
// Purpose: Two-wire slave port, register file and scan control of the driver
// Assumes: Pins are asynchronous and pass a three-stage filter
// Notes:   Data pin is open drain: only low is ever driven

`timescale 1ns/100ps

module lmi_ctrl #(
    parameter int BLANK_CYC   = lmi_pkg::BLANK_CYC,
    parameter int STAGGER_CYC = lmi_pkg::STAGGER_CYC,
    parameter int SCAN_CYC    = lmi_pkg::SCAN_CYC
) (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    // Two-wire port
    input  wire logic                         scl_i,
    input  wire logic                         sda_i,
    output logic                              sda_o,
    output logic                              sda_oe_n_o,
    // Shutdown
    input  wire logic                         shutdown_n_pin_i,
    // Matrix drive
    output logic [lmi_pkg::ROWS_MAX-1:0]      row_source_outputs_o,
    output logic [lmi_pkg::COLS_MAX-1:0]      column_sink_outputs_o,
    output logic [6:0]                        current_level_o
);

    // ------------------------------------------------------------------
    // State and reset image
    // ------------------------------------------------------------------
    localparam lmi_pkg::lmi_top_s RESET_IMAGE = '{
        scl_sync : 3'h7,
        sda_sync : 3'h7,
        sdn_sync : 3'h0,
        scl_s    : 1'b1,
        sda_s    : 1'b1,
        sdn_s    : 1'b0,
        st       : lmi_pkg::ST_IDLE,
        ack_next : lmi_pkg::ST_IDLE,
        bit_cnt  : 3'h0,
        full     : 1'b0,
        shift    : 8'h00,
        ptr      : 8'h00,
        sda_oe_n : 1'b1,
        level    : 7'h00,
        regs     : '0
    };

    lmi_pkg::lmi_top_s q;
    lmi_pkg::lmi_top_s d;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic sdn_rise;
    logic run;

    // ------------------------------------------------------------------
    // Register helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] read_reg(
        input lmi_pkg::lmi_top_s s,
        input logic [7:0]        idx
    );
        logic [7:0] v;
        v = 8'h00;
        // Enable register is write only; beyond the map reads zero
        if (idx < 8'(lmi_pkg::REG_COUNT) && idx != lmi_pkg::REG_OS_EN) begin
            v = s.regs[idx[3:0]];
        end
        return v;
    endfunction

    function automatic logic writable(input logic [7:0] idx);
        return (idx < 8'(lmi_pkg::REG_COUNT)) &&
               (idx != lmi_pkg::REG_OS_STAT);
    endfunction

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;

        // Three-stage filters; a level counts once stages two and three agree
        d.scl_sync = {q.scl_sync[1:0], scl_i};
        d.sda_sync = {q.sda_sync[1:0], sda_i};
        d.sdn_sync = {q.sdn_sync[1:0], shutdown_n_pin_i};
        if (q.scl_sync[2] == q.scl_sync[1]) begin
            d.scl_s = q.scl_sync[2];
        end
        if (q.sda_sync[2] == q.sda_sync[1]) begin
            d.sda_s = q.sda_sync[2];
        end
        if (q.sdn_sync[2] == q.sdn_sync[1]) begin
            d.sdn_s = q.sdn_sync[2];
        end

        scl_rise  = !q.scl_s && d.scl_s;
        scl_fall  = q.scl_s && !d.scl_s;
        bus_start = q.scl_s && d.scl_s && q.sda_s && !d.sda_s;
        bus_stop  = q.scl_s && d.scl_s && !q.sda_s && d.sda_s;
        sdn_rise  = !q.sdn_s && d.sdn_s;

        if (!d.sdn_s || sdn_rise) begin
            d.st       = lmi_pkg::ST_IDLE;
            d.ack_next = lmi_pkg::ST_IDLE;
            d.bit_cnt  = 3'h0;
            d.full     = 1'b0;
            d.shift    = 8'h00;
            d.ptr      = 8'h00;
            d.sda_oe_n = 1'b1;
        end else if (bus_start) begin
            // A repeated start lands here too and keeps the pointer
            d.st       = lmi_pkg::ST_ADDR;
            d.bit_cnt  = 3'h0;
            d.full     = 1'b0;
            d.sda_oe_n = 1'b1;
        end else if (bus_stop) begin
            d.st       = lmi_pkg::ST_IDLE;
            d.full     = 1'b0;
            d.sda_oe_n = 1'b1;
        end else begin
            unique case (q.st)
                lmi_pkg::ST_IDLE: begin
                    d.sda_oe_n = 1'b1;
                end

                lmi_pkg::ST_ADDR, lmi_pkg::ST_PTR, lmi_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        d.shift   = {q.shift[6:0], d.sda_s};
                        d.bit_cnt = q.bit_cnt + 3'h1;
                        d.full    = (q.bit_cnt == 3'h7);
                    end
                    if (scl_fall && q.full) begin
                        d.full     = 1'b0;
                        d.bit_cnt  = 3'h0;
                        d.st       = lmi_pkg::ST_ACK;
                        d.sda_oe_n = 1'b0;
                        if (q.st == lmi_pkg::ST_ADDR) begin
                            if (q.shift[7:1] != lmi_pkg::BUS_ADDR) begin
                                d.st       = lmi_pkg::ST_IDLE;
                                d.sda_oe_n = 1'b1;
                            end else if (q.shift[0]) begin
                                d.ack_next = lmi_pkg::ST_RDATA;
                            end else begin
                                d.ack_next = lmi_pkg::ST_PTR;
                            end
                        end else if (q.st == lmi_pkg::ST_PTR) begin
                            d.ptr      = q.shift;
                            d.ack_next = lmi_pkg::ST_WDATA;
                        end else begin
                            if (writable(q.ptr)) begin
                                d.regs[q.ptr[3:0]] = q.shift;
                            end
                            d.ptr      = q.ptr + 8'h01;
                            d.ack_next = lmi_pkg::ST_WDATA;
                        end
                    end
                end

                lmi_pkg::ST_ACK: begin
                    // Release only at the end of the ninth pulse
                    if (scl_fall) begin
                        d.st       = q.ack_next;
                        d.sda_oe_n = 1'b1;
                        if (q.ack_next == lmi_pkg::ST_RDATA) begin
                            d.shift    = read_reg(q, q.ptr);
                            d.sda_oe_n = d.shift[7];
                        end
                    end
                end

                lmi_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        if (q.bit_cnt == 3'h7) begin
                            d.st       = lmi_pkg::ST_MACK;
                            d.bit_cnt  = 3'h0;
                            d.full     = 1'b0;
                            d.sda_oe_n = 1'b1;
                        end else begin
                            d.shift    = {q.shift[6:0], 1'b0};
                            d.bit_cnt  = q.bit_cnt + 3'h1;
                            d.sda_oe_n = d.shift[7];
                        end
                    end
                end

                lmi_pkg::ST_MACK: begin
                    // Low from the master asks for the next byte
                    if (scl_rise) begin
                        d.full = !d.sda_s;
                    end
                    if (scl_fall) begin
                        d.full = 1'b0;
                        if (q.full) begin
                            d.ptr      = q.ptr + 8'h01;
                            d.shift    = read_reg(q, d.ptr);
                            d.sda_oe_n = d.shift[7];
                            d.st       = lmi_pkg::ST_RDATA;
                        end else begin
                            d.st = lmi_pkg::ST_IDLE;
                        end
                    end
                end

                default: begin
                    d.st       = lmi_pkg::ST_IDLE;
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end

        run     = d.sdn_s && q.regs[lmi_pkg::REG_CFG][lmi_pkg::CFG_RUN_BIT];
        d.level = run ? q.regs[lmi_pkg::REG_GCC][6:0] : 7'h00;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q                            <= RESET_IMAGE;
            q.regs[lmi_pkg::REG_CFG]     <= lmi_pkg::CFG_RESET;
            q.regs[lmi_pkg::REG_GCC]     <= lmi_pkg::GCC_RESET;
            q.regs[lmi_pkg::REG_SCAN]    <= lmi_pkg::SCAN_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Scan geometry from configuration
    // ------------------------------------------------------------------
    logic [2:0] mode;
    logic [2:0] rate;
    logic [2:0] row_count;
    logic [3:0] col_count;
    logic [6:0] rate_mult;
    logic [lmi_pkg::COLS_MAX-1:0][lmi_pkg::ROWS_MAX-1:0] onoff;

    assign mode = q.regs[lmi_pkg::REG_CFG][lmi_pkg::CFG_MODE_LSB +: 3];
    assign rate = q.regs[lmi_pkg::REG_SCAN][lmi_pkg::SCAN_RATE_LSB +: 3];

    always_comb begin
        row_count = 3'h7;
        col_count = 4'h8;
        unique case (mode)
            3'h0, 3'h7: begin
                row_count = 3'h7;
                col_count = 4'h8;
            end
            3'h1: begin
                row_count = 3'h6;
                col_count = 4'h9;
            end
            3'h2, 3'h3, 3'h4, 3'h5, 3'h6: begin
                row_count = 3'h7 - mode;
                col_count = 4'ha;
            end
        endcase
    end

    // Ratios of the slower scan rates, the two fastest rounded to whole steps
    always_comb begin
        rate_mult = 7'h01;
        unique case (rate)
            3'h0, 3'h1: rate_mult = 7'h01;
            3'h2:       rate_mult = 7'h02;
            3'h3:       rate_mult = 7'h06;
            3'h4:       rate_mult = 7'h0c;
            3'h5:       rate_mult = 7'h19;
            3'h6:       rate_mult = 7'h32;
            3'h7:       rate_mult = 7'h64;
        endcase
    end

    for (genvar c = 0; c < lmi_pkg::COLS_MAX; c++) begin : g_onoff
        assign onoff[c] =
            q.regs[int'(lmi_pkg::REG_ONOFF_0) + c][lmi_pkg::ROWS_MAX-1:0];
    end

    lmi_pkg::lmi_drive_s drive;

    lmi_scan_seq #(
        .BLANK_CYC   (BLANK_CYC),
        .STAGGER_CYC (STAGGER_CYC),
        .SCAN_CYC    (SCAN_CYC)
    ) u_scan (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .en_i        (q.sdn_s &&
                      q.regs[lmi_pkg::REG_CFG][lmi_pkg::CFG_RUN_BIT]),
        .row_count_i (row_count),
        .col_count_i (col_count),
        .rate_mult_i (rate_mult),
        .onoff_i     (onoff),
        .drive_o     (drive)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sda_o                 = 1'b0;
    assign sda_oe_n_o            = q.sda_oe_n;
    assign row_source_outputs_o  = drive.row;
    assign column_sink_outputs_o = drive.col;
    assign current_level_o       = q.level;

endmodule // lmi_ctrl

// ---- verif/lmi_ctrl_checker.sv ----
// Purpose: Port checks of the LED matrix controller
// Assumes: Default 8x7 mode, rate code 1, SCAN_CYC of 5
// Notes:   Bound onto lmi_ctrl

`timescale 1ns/100ps

module lmi_ctrl_checker #(
    parameter int BLANK_CYC   = 2,
    parameter int STAGGER_CYC = 1,
    parameter int SCAN_CYC    = 5
) (
    // Clock and reset
    input wire logic                         clk_i,
    input wire logic                         rst_i,
    // Pins
    input wire logic                         scl_i,
    input wire logic                         sda_i,
    input wire logic                         sda_o,
    input wire logic                         sda_oe_n_o,
    input wire logic                         shutdown_n_pin_i,
    input wire logic [lmi_pkg::ROWS_MAX-1:0] row_source_outputs_o,
    input wire logic [lmi_pkg::COLS_MAX-1:0] column_sink_outputs_o,
    input wire logic [6:0]                   current_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Row held for five cycles with SCAN_CYC of 5 and multiplier 1
    sequence s_row_on;
        ($stable(row_source_outputs_o) && row_source_outputs_o != 0)[*4];
    endsequence

    property p_row_hold;
        disable iff (rst_i || !shutdown_n_pin_i)
        $rose(|row_source_outputs_o) |=> s_row_on ##1
            (row_source_outputs_o == 0);
    endproperty

    a_sda_const: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    a_oe_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("data driver moved while bus clock high");
    a_shut_quiet: assert property ((!shutdown_n_pin_i)[*6] |->
        row_source_outputs_o == 0 && column_sink_outputs_o == 0 &&
        current_level_o == 0 && sda_oe_n_o)
        else $error("activity while shut down");
    a_row_onehot: assert property ($onehot0(row_source_outputs_o))
        else $error("more than one row on");
    a_cols_need_row: assert property (
        column_sink_outputs_o != 0 |-> row_source_outputs_o != 0)
        else $error("column on during blanking");
    a_blank_gap: assert property ($rose(|row_source_outputs_o) |->
        $past(row_source_outputs_o, 2) == 0)
        else $error("blanking gap too short");
    a_row_hold: assert property (p_row_hold)
        else $error("row on time wrong");
    a_col_stagger: assert property ($rose(|row_source_outputs_o) |->
        column_sink_outputs_o[9:5] == 0)
        else $error("late columns on with row");
    a_cols_masked: assert property (column_sink_outputs_o[9:8] == 0)
        else $error("unused columns on in 8x7 mode");
endmodule // lmi_ctrl_checker

bind lmi_ctrl lmi_ctrl_checker #(
    .BLANK_CYC   (BLANK_CYC),
    .STAGGER_CYC (STAGGER_CYC),
    .SCAN_CYC    (SCAN_CYC)
) u_chk (.*);

// ---- verif/lmi_bus_master.sv ----
// Purpose: Two-wire bus master model facing the controller
// Assumes: Wire level is resolved by the bench
// Notes:   Clock low 500 ns, high 300 ns: an 800 ns bit period

`timescale 1ns/100ps

module lmi_bus_master (
    // Bus
    output logic       scl_o,
    output logic       sda_o,
    input wire logic   sda_i,
    // Results
    output logic [7:0] got_o,
    output int         got_n_o
);
    initial begin
        scl_o   = 1'b1;
        sda_o   = 1'b1;
        got_o   = 8'h00;
        got_n_o = 0;
    end

    // Data moves only in the low phase; sampled late in the high phase
    task automatic bit_io(input logic b, output logic r);
        #200 sda_o = b;
        #300 scl_o = 1'b1;
        #300 r = sda_i;
        scl_o = 1'b0;
    endtask

    task automatic start();
        #200 sda_o = 1'b1;
        #300 scl_o = 1'b1;
        #300 sda_o = 1'b0;
        #300 scl_o = 1'b0;
    endtask

    task automatic stop();
        #200 sda_o = 1'b0;
        #300 scl_o = 1'b1;
        #300 sda_o = 1'b1;
        #300;
    endtask

    task automatic wr(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        got_o = {7'h00, r};
        got_n_o++;
    endtask

    task automatic rd(input logic last);
        logic [7:0] v;
        logic       r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            v[i] = r;
        end
        bit_io(last, r);
        got_o = v;
        got_n_o++;
    endtask
endmodule // lmi_bus_master

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench of the LED matrix controller
// Assumes: SCAN_CYC shortened to 5
// Notes:   Expected bus results queue up and are matched in order

`timescale 1ns/100ps

module tb_top;
    logic       clk_i = 1'b0;
    logic       rst_i = 1'b1;
    logic       sdn   = 1'b1;
    logic       scl, sda_m, sda_o, oe_n;
    wire logic  sda = sda_m & (oe_n ? 1'b1 : sda_o);
    logic [6:0] row, lvl;
    logic [9:0] col;
    logic [7:0] got, g, a;
    logic [8:0] e;
    logic [8:0] exp_q[$];
    int         got_n, fails = 0, compares = 0, cyc = 0, seed = 26234;

    lmi_ctrl #(.SCAN_CYC(5)) DUT (.clk_i(clk_i), .rst_i(rst_i),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n),
        .shutdown_n_pin_i(sdn), .row_source_outputs_o(row),
        .column_sink_outputs_o(col), .current_level_o(lvl));
    lmi_bus_master u_mst (.scl_o(scl), .sda_o(sda_m), .sda_i(sda),
        .got_o(got), .got_n_o(got_n));

    initial forever #50 clk_i = ~clk_i;

    task report_and_stop();
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task chk_ack(input logic got_v, input logic exp_v);
        compares++;
        if (got_v !== exp_v) begin
            fails++;
            $display("ERROR %0t ack bit %b exp %b", $time, got_v, exp_v);
        end
    endtask

    task chk_val(input logic [9:0] got_v, input logic [9:0] exp_v);
        compares++;
        if (got_v !== exp_v) begin
            fails++;
            $display("ERROR %0t value %h exp %h", $time, got_v, exp_v);
        end
    endtask

    task wb(input logic [7:0] b, input logic ack);
        exp_q.push_back({1'b0, 7'h00, ~ack});
        u_mst.wr(b);
    endtask

    task rb(input logic [7:0] v, input logic last);
        exp_q.push_back({1'b1, v});
        u_mst.rd(last);
    endtask

    // Let the result byte settle before it is taken
    always @(got_n) begin
        #1 e = exp_q.pop_front();
        if (e[8]) chk_val({2'b00, got}, {2'b00, e[7:0]});
        else chk_ack(got[0], e[0]);
    end

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 12000) begin
            fails++;
            $display("ERROR %0t run too long", $time);
            report_and_stop();
        end
    end

    initial begin
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (10) @(negedge clk_i);
        chk_val({3'b000, lvl}, 10'h07f);
        g = 8'($random(seed)) & 8'h7f;
        u_mst.start();
        wb(8'hb4, 1'b1);
        wb(8'h0b, 1'b1);
        wb(g, 1'b1);
        wb(8'h01, 1'b1);
        u_mst.stop();
        repeat (6) @(negedge clk_i);
        chk_val({3'b000, lvl}, {3'b000, g[6:0]});
        u_mst.start();
        wb(8'hb4, 1'b1);
        wb(8'h0b, 1'b1);
        u_mst.start();
        wb(8'hb5, 1'b1);
        rb(g, 1'b0);
        rb(8'h01, 1'b1);
        u_mst.stop();
        // Foreign addresses, the first one bit away from ours
        for (int i = 0; i < 4; i++) begin
            a = (i == 0) ? 8'hb6 : 8'($random(seed));
            if (a[7:1] == 7'h5a) a ^= 8'h02;
            u_mst.start();
            wb(a, 1'b0);
            u_mst.stop();
        end
        u_mst.start();
        wb(8'hb4, 1'b1);
        wb(8'h01, 1'b1);
        for (int i = 0; i < 10; i++) wb(8'h7f, 1'b1);
        u_mst.stop();
        // Wait for a fresh row so its first on cycle is seen
        while (row != 0) @(negedge clk_i);
        for (int i = 0; i < 100 && row == 0; i++) @(negedge clk_i);
        chk_val(col, 10'h01f);
        @(negedge clk_i);
        chk_val(col, 10'h0ff);
        sdn = 1'b0;
        repeat (8) @(negedge clk_i);
        chk_val({row, lvl[2:0]}, 10'h000);
        u_mst.start();
        wb(8'hb4, 1'b0);
        u_mst.stop();
        sdn = 1'b1;
        repeat (8) @(negedge clk_i);
        u_mst.start();
        wb(8'hb4, 1'b1);
        wb(8'h0b, 1'b1);
        u_mst.start();
        wb(8'hb5, 1'b1);
        rb(g, 1'b1);
        u_mst.stop();
        repeat (20) @(negedge clk_i);
        report_and_stop();
    end
endmodule // tb_top
